// File: core/dic_cfg.svh
// Purpose: Constants for the digital input conditioner.
// Assumes: 50 MHz core clock; delays are counted in milliseconds.
// Notes: Definitions only, no logic.
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH

// ****************************************
// Channel counts and widths
// ****************************************
`define DIC_BUILTIN_NUM 3
`define DIC_EXP_NUM 8
`define DIC_CHAN_NUM 11
`define DIC_DELAY_W 21
`define DIC_TIMER_W 22
`define DIC_VOLT_W 9
`define DIC_NUM_W 8
`define DIC_SCAN_CNT_W 18

// ****************************************
// Timing
// ****************************************
`define DIC_CLK_HZ 50000000
`define DIC_SCAN_TIME_US 5000
`define DIC_SCAN_CYCLES ((`DIC_CLK_HZ / 1000000) * `DIC_SCAN_TIME_US)
`define DIC_SCAN_MS 22'h000005
`define DIC_AC_EXTRA_MS 22'h00001e

// ****************************************
// Thresholds and reset values
// ****************************************
`define DIC_AC_REL_PCT 16'h000a
`define DIC_PCT_FULL 16'h0064
`define DIC_TIMER_ZERO 22'h000000
`define DIC_SCAN_ZERO 18'h00000
`define DIC_NUM_ONE 8'h01

`endif

// File: core/dic_pkg.sv
// Purpose: Types shared by the digital input conditioner files.
// Assumes: dic_cfg.svh supplies the widths.
// Notes: Types only; numbers live in the header.
`include "dic_cfg.svh"

package dic_pkg;

  typedef logic [`DIC_DELAY_W-1:0] dic_delay_t;
  typedef logic [`DIC_TIMER_W-1:0] dic_timer_t;
  typedef logic [`DIC_VOLT_W-1:0] dic_volt_t;
  typedef logic [`DIC_NUM_W-1:0] dic_num_t;

  typedef enum logic [0:0] {
    DIC_STABLE = 1'b0,
    DIC_TIMING = 1'b1
  } dic_timer_e;

endpackage : dic_pkg

// File: core/dic_delay_timer.sv
// Purpose: Pick-up and release delay timer of one input channel.
// Assumes: scanTick pulses once per scan; rstN is already synchronised.
// Notes: Elapsed time is kept in milliseconds and advanced one scan step per tick.
`timescale 1ns/1ps
`include "dic_cfg.svh"

module dic_delay_timer (
  input wire logic clk,
  input wire logic rstN,
  input wire logic scanTick,
  input wire logic rawState,
  input wire dic_pkg::dic_delay_t pickupDelay,
  input wire dic_pkg::dic_delay_t releaseDelay,
  input wire logic alternatingSupplyOption,
  output logic reportedState
);
  import dic_pkg::*;

  dic_timer_e state_reg, state_next;
  dic_timer_t elapsed_reg, elapsed_next;
  logic reported_reg, reported_next;
  dic_timer_t target;
  dic_timer_t acExtra;

  assign acExtra = alternatingSupplyOption ? `DIC_AC_EXTRA_MS : `DIC_TIMER_ZERO;
  assign target = reported_reg ? (dic_timer_t'(releaseDelay) + acExtra)
                               : dic_timer_t'(pickupDelay);

  // ****************************************
  // Timer sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    reported_next = reported_reg;
    if (scanTick) begin
      case (state_reg)
        DIC_STABLE: begin
          elapsed_next = `DIC_TIMER_ZERO;
          if (rawState != reported_reg) begin
            if (target == `DIC_TIMER_ZERO) begin
              reported_next = rawState;
            end else begin
              state_next = DIC_TIMING;
              elapsed_next = `DIC_SCAN_MS;
            end
          end
        end
        DIC_TIMING: begin
          if (rawState == reported_reg) begin
            // Raw reverted: drop the run so the next change starts afresh
            state_next = DIC_STABLE;
            elapsed_next = `DIC_TIMER_ZERO;
          end else if (elapsed_reg >= target) begin
            reported_next = rawState;
            state_next = DIC_STABLE;
            elapsed_next = `DIC_TIMER_ZERO;
          end else begin
            elapsed_next = elapsed_reg + `DIC_SCAN_MS;
          end
        end
        default: begin
          state_next = DIC_STABLE;
          elapsed_next = `DIC_TIMER_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= DIC_STABLE;
      elapsed_reg <= `DIC_TIMER_ZERO;
      reported_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      reported_reg <= reported_next;
    end
  end

  assign reportedState = reported_reg;

endmodule : dic_delay_timer

// File: core/dic_input_conditioner.sv
// Purpose: Digital input conditioner: scan, polarity, thresholds, delays, consumer stages.
// Assumes: Built-in inputs arrive as asynchronous pin levels; expansion voltages come
//   from on-chip measurement logic on core_clk, in whole volts.
// Notes: All settings are plain ports; zero on a setting port gives its default.
`timescale 1ns/1ps
`include "dic_cfg.svh"

// Overview of operation
// - Every input is sampled once per 5 ms scan, so its state updates 0 to 5 ms after a change.
// - Each input has a sense select, normally open by default, reporting 1 when energized, else inverted.
// - A 0-to-1 change of the reported state is held off by a pick-up delay of up to 1800 s in 1 ms steps.
// - A 1-to-0 change of the reported state is held off by a separate release delay of the same range.
// - With the alternating supply option on, 30 ms is added to the input's release delay; default off.
// - Internal consumers see the new state one scan later, 0 to 10 ms after the input change.
// - A directly routed output follows one more scan later, 0 to 15 ms after the input change.
// - Expansion inputs have pick-up and release voltage thresholds set per input in 1 V steps.
// - The eight expansion channels are numbered on from the count of inputs on preceding modules.
// - Above the pick-up threshold the channel is energized, below the release threshold it is not.
// - With the alternating supply option on, the release threshold is 10 percent of the pick-up one.
module dic_input_conditioner #(
  parameter int SCAN_CYCLES = `DIC_SCAN_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`DIC_BUILTIN_NUM-1:0] builtinInputPin,
  input wire logic [`DIC_EXP_NUM*`DIC_VOLT_W-1:0] expansionVoltage,
  input wire logic [`DIC_EXP_NUM*`DIC_VOLT_W-1:0] pickupThreshold,
  input wire logic [`DIC_EXP_NUM*`DIC_VOLT_W-1:0] releaseThreshold,
  input wire logic [`DIC_CHAN_NUM-1:0] inputSenseSelect,
  input wire logic [`DIC_CHAN_NUM*`DIC_DELAY_W-1:0] pickupDelay,
  input wire logic [`DIC_CHAN_NUM*`DIC_DELAY_W-1:0] releaseDelay,
  input wire logic [`DIC_CHAN_NUM-1:0] alternatingSupplyOption,
  input wire logic [`DIC_CHAN_NUM-1:0] directRouteEnable,
  input wire dic_pkg::dic_num_t precedingInputCount,
  output logic scanStrobe,
  output logic [`DIC_CHAN_NUM-1:0] digitalInputState,
  output logic [`DIC_CHAN_NUM-1:0] logicInputState,
  output logic [`DIC_CHAN_NUM-1:0] digitalOutputCommand,
  output logic [`DIC_EXP_NUM*`DIC_NUM_W-1:0] expansionChannelNumber
);
  import dic_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Release level actually in force for one expansion channel
  function automatic dic_volt_t effRelease(input dic_volt_t pickup, input dic_volt_t userRelease,
                                           input logic acOn);
    logic [15:0] scaled;
    scaled = ({7'h00, pickup} * `DIC_AC_REL_PCT) / `DIC_PCT_FULL;
    effRelease = acOn ? scaled[`DIC_VOLT_W-1:0] : userRelease;
  endfunction : effRelease

  // ****************************************
  // Reset release
  // ****************************************
  // Release is synchronised so every flop reset by rstN leaves reset on the same edge
  logic rstSync1_reg;
  logic rstSync2_reg;
  logic rstN;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  assign rstN = rstSync2_reg;

  // ****************************************
  // Scan cycle timebase
  // ****************************************
  localparam logic [`DIC_SCAN_CNT_W-1:0] SCAN_LAST = `DIC_SCAN_CNT_W'(SCAN_CYCLES - 1);

  logic [`DIC_SCAN_CNT_W-1:0] scanCnt_reg;
  logic [`DIC_SCAN_CNT_W-1:0] scanCnt_next;
  logic scanTick_reg;
  logic scanTick_next;
  wire scanWrap = (scanCnt_reg == SCAN_LAST);

  assign scanCnt_next = scanWrap ? `DIC_SCAN_ZERO : scanCnt_reg + 1'b1;
  assign scanTick_next = scanWrap;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      scanCnt_reg <= `DIC_SCAN_ZERO;
    end else begin
      scanCnt_reg <= scanCnt_next;
    end
  end

  // Strobe is registered so consumers never see a combinational glitch
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      scanTick_reg <= 1'b0;
    end else begin
      scanTick_reg <= scanTick_next;
    end
  end

  assign scanStrobe = scanTick_reg;

  // ****************************************
  // Built-in pin synchronisers
  // ****************************************
  // Pins are asynchronous: only the second flop is read by logic
  logic [`DIC_BUILTIN_NUM-1:0] pinMeta_reg;
  logic [`DIC_BUILTIN_NUM-1:0] pinSync_reg;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else begin
      pinMeta_reg <= builtinInputPin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // ****************************************
  // Expansion thresholds with hysteresis
  // ****************************************
  logic [`DIC_EXP_NUM-1:0] expEnergized_reg;
  logic [`DIC_EXP_NUM-1:0] expEnergized_next;
  logic [`DIC_EXP_NUM*`DIC_NUM_W-1:0] chanNum_reg;
  logic [`DIC_EXP_NUM*`DIC_NUM_W-1:0] chanNum_next;

  genvar e;
  generate
    for (e = 0; e < `DIC_EXP_NUM; e++) begin : gExp
      wire dic_volt_t volt = expansionVoltage[e*`DIC_VOLT_W +: `DIC_VOLT_W];
      wire dic_volt_t pick = pickupThreshold[e*`DIC_VOLT_W +: `DIC_VOLT_W];
      wire dic_volt_t rel = effRelease(pick, releaseThreshold[e*`DIC_VOLT_W +: `DIC_VOLT_W],
                                       alternatingSupplyOption[`DIC_BUILTIN_NUM + e]);
      wire aboveOn = volt > pick;
      wire belowOff = volt < rel;
      // Between the two levels the last decision holds, so a noisy edge cannot chatter
      assign expEnergized_next[e] = aboveOn ? 1'b1 : (belowOff ? 1'b0 : expEnergized_reg[e]);
      assign chanNum_next[e*`DIC_NUM_W +: `DIC_NUM_W] =
        precedingInputCount + `DIC_NUM_W'(e) + `DIC_NUM_ONE;
    end
  endgenerate

  // ****************************************
  // Expansion channel numbering and energized state
  // ****************************************
  // Number is registered so the channel label never glitches while the count changes
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      chanNum_reg <= '0;
    end else begin
      chanNum_reg <= chanNum_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      expEnergized_reg <= '0;
    end else begin
      expEnergized_reg <= expEnergized_next;
    end
  end

  // ****************************************
  // Per-channel conditioning
  // ****************************************
  wire [`DIC_CHAN_NUM-1:0] energized = {expEnergized_reg, pinSync_reg};
  // Sense select 0 is normally open: energized reports 1
  wire [`DIC_CHAN_NUM-1:0] rawState = energized ^ inputSenseSelect;
  logic [`DIC_CHAN_NUM-1:0] reported;
  logic [`DIC_CHAN_NUM-1:0] logic_reg;
  logic [`DIC_CHAN_NUM-1:0] logic_next;
  logic [`DIC_CHAN_NUM-1:0] outCmd_reg;
  logic [`DIC_CHAN_NUM-1:0] outCmd_next;

  genvar c;
  generate
    for (c = 0; c < `DIC_CHAN_NUM; c++) begin : gChan
      dic_delay_timer uTimer (
        .clk(core_clk),
        .rstN(rstN),
        .scanTick(scanTick_reg),
        .rawState(rawState[c]),
        .pickupDelay(pickupDelay[c*`DIC_DELAY_W +: `DIC_DELAY_W]),
        .releaseDelay(releaseDelay[c*`DIC_DELAY_W +: `DIC_DELAY_W]),
        .alternatingSupplyOption(alternatingSupplyOption[c]),
        .reportedState(reported[c])
      );
    end
  endgenerate

  // ****************************************
  // Consumer stages, one scan apart
  // ****************************************
  // Stages move only on the scan strobe, mimicking the program cycle of the consumers
  assign logic_next = scanTick_reg ? reported : logic_reg;
  assign outCmd_next = scanTick_reg ? (logic_reg & directRouteEnable) : outCmd_reg;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      logic_reg <= '0;
    end else begin
      logic_reg <= logic_next;
    end
  end

  // Route mask is applied live, so a disabled route drops its output one scan later
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      outCmd_reg <= '0;
    end else begin
      outCmd_reg <= outCmd_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign digitalInputState = reported;
  assign logicInputState = logic_reg;
  assign digitalOutputCommand = outCmd_reg;
  assign expansionChannelNumber = chanNum_reg;

endmodule : dic_input_conditioner

// File: testbench/dic_input_conditioner_assertions.sv
// Purpose: Port checks for the input conditioner.
// Assumes: Bound into dic_input_conditioner.
// Notes: Helper counters mirror the scan contract.
`timescale 1ns/1ps
`include "dic_cfg.svh"
module dic_input_conditioner_assertions #(
  parameter int SCAN_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`DIC_BUILTIN_NUM-1:0] builtinInputPin,
  input wire logic [`DIC_CHAN_NUM-1:0] inputSenseSelect,
  input wire logic [`DIC_CHAN_NUM*`DIC_DELAY_W-1:0] pickupDelay,
  input wire logic [`DIC_CHAN_NUM*`DIC_DELAY_W-1:0] releaseDelay,
  input wire logic [`DIC_CHAN_NUM-1:0] alternatingSupplyOption,
  input wire logic [`DIC_CHAN_NUM-1:0] directRouteEnable,
  input wire dic_pkg::dic_num_t precedingInputCount,
  input wire logic scanStrobe,
  input wire logic [`DIC_CHAN_NUM-1:0] digitalInputState,
  input wire logic [`DIC_CHAN_NUM-1:0] logicInputState,
  input wire logic [`DIC_CHAN_NUM-1:0] digitalOutputCommand,
  input wire logic [`DIC_EXP_NUM*`DIC_NUM_W-1:0] expansionChannelNumber
);
  import dic_pkg::*;
  // ****
  // Helpers
  // ****
  // Outputs stay zero while the synced reset is still held
  logic [1:0] upCnt_reg;
  logic [5:0] hist_reg;
  logic [3:0] runCnt_reg;
  int gap_reg;
  wire up = upCnt_reg == 2'h3;
  wire raw0 = hist_reg[2] ^ inputSenseSelect[0];
  wire raw1 = hist_reg[3] ^ inputSenseSelect[1];
  wire steady0 = (builtinInputPin[0] == hist_reg[0]) && (hist_reg[0] == hist_reg[2]) && (hist_reg[2] == hist_reg[4]);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      upCnt_reg <= 2'h0;
      hist_reg <= 6'h00;
      runCnt_reg <= 4'h0;
      gap_reg <= -4 * SCAN_CYCLES;
    end else begin
      upCnt_reg <= up ? upCnt_reg : upCnt_reg + 2'h1;
      hist_reg <= {hist_reg[3:0], builtinInputPin[1:0]};
      gap_reg <= scanStrobe ? 0 : gap_reg + 1;
      if (scanStrobe && up) begin
        runCnt_reg <= (raw1 != digitalInputState[1]) ? runCnt_reg + 4'h1 : 4'h0;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!up);
  a_scan_period: assert property (scanStrobe && gap_reg >= 0 |-> gap_reg == SCAN_CYCLES - 1)
    else $error("scan strobe spacing wrong");
  a_state_on_scan: assert property ($changed(digitalInputState) |-> $past(scanStrobe))
    else $error("input state moved off scan");
  a_logic_follow: assert property (scanStrobe |=> logicInputState == $past(digitalInputState))
    else $error("logic state lags wrongly");
  a_route_follow: assert property (scanStrobe |=> digitalOutputCommand ==
    ($past(logicInputState) & $past(directRouteEnable))) else $error("output command wrong");
  a_chan_number: assert property (1'b1 |=> {expansionChannelNumber[63:56], expansionChannelNumber[7:0]} ==
    {$past(precedingInputCount) + 8'h08, $past(precedingInputCount) + 8'h01}) else $error("channel number wrong");
  a_zero_delay: assert property (scanStrobe && steady0 && pickupDelay[20:0] == 21'h0 &&
    releaseDelay[20:0] == 21'h0 && !alternatingSupplyOption[0] |=> digitalInputState[0] == $past(raw0))
    else $error("undelayed input wrong");
  a_pickup_delay: assert property ($rose(digitalInputState[1]) && pickupDelay[41:21] == 21'h00000f |->
    runCnt_reg == 4'h4) else $error("pickup delay wrong");
  a_ac_release: assert property ($fell(digitalInputState[1]) && alternatingSupplyOption[1] &&
    releaseDelay[41:21] == 21'h0 |-> runCnt_reg == 4'h7) else $error("ac release wrong");
endmodule : dic_input_conditioner_assertions
bind dic_input_conditioner dic_input_conditioner_assertions #(.SCAN_CYCLES(SCAN_CYCLES)) chk (
  .core_clk, .reset_n, .builtinInputPin, .inputSenseSelect, .pickupDelay, .releaseDelay,
  .alternatingSupplyOption, .directRouteEnable, .precedingInputCount, .scanStrobe,
  .digitalInputState, .logicInputState, .digitalOutputCommand, .expansionChannelNumber);

// File: testbench/dic_field_model.sv
// Purpose: Field side: contact pins and channel voltages.
// Assumes: Targets change at the falling edge.
// Notes: Pins move off the clock grid.
`timescale 1ns/1ps
module dic_field_model (
  input wire logic core_clk,
  input wire logic [2:0] energize,
  input wire logic [71:0] voltTarget,
  output logic [2:0] builtinInputPin,
  output logic [71:0] expansionVoltage
);
  // ****
  // Field behaviour
  // ****
  initial builtinInputPin = 3'h0;
  initial expansionVoltage = 72'h0;
  always @(energize) builtinInputPin <= #7 energize;
  // Slew limited, so a step crosses every level on the way
  always @(posedge core_clk) begin : ramp
    logic [8:0] c, t;
    for (int e = 0; e < 8; e++) begin
      c = expansionVoltage[e*9+:9];
      t = voltTarget[e*9+:9];
      if (c + 9'h010 < t) c = c + 9'h010;
      else if (c > t + 9'h010) c = c - 9'h010;
      else c = t;
      expansionVoltage[e*9+:9] <= c;
    end
  end
endmodule : dic_field_model

// File: testbench/dic_input_conditioner_tb.sv
// Purpose: Self-checking bench for the input conditioner.
// Assumes: Scan cut to 8 clocks; delays still count 5 ms a scan.
// Notes: Checks land one cycle after the scan strobe.
`timescale 1ns/1ps
`include "dic_cfg.svh"
module dic_input_conditioner_tb;
  import dic_pkg::*;
  logic core_clk, reset_n, scanStrobe;
  logic [2:0] energize, pins;
  logic [71:0] voltTarget, volts, pickupThreshold, releaseThreshold, chanNum;
  logic [10:0] sense, acOpt, route, state, logicState, outCmd;
  logic [230:0] pickupDelay, releaseDelay;
  dic_num_t count;
  logic [8:0] vTab [0:6] = '{9'h078, 9'h050, 9'h032, 9'h050, 9'h078, 9'h032, 9'h005};
  logic [1:0] eTab [0:6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h3, 2'h2};
  int n_mismatch = 0;
  int n_compared = 0;
  dic_input_conditioner #(.SCAN_CYCLES(8)) uut (.core_clk, .reset_n, .builtinInputPin(pins),
    .expansionVoltage(volts), .pickupThreshold, .releaseThreshold, .inputSenseSelect(sense),
    .pickupDelay, .releaseDelay, .alternatingSupplyOption(acOpt), .directRouteEnable(route),
    .precedingInputCount(count), .scanStrobe, .digitalInputState(state), .logicInputState(logicState),
    .digitalOutputCommand(outCmd), .expansionChannelNumber(chanNum));
  dic_field_model field (.core_clk, .energize, .voltTarget, .builtinInputPin(pins), .expansionVoltage(volts));
  // ****
  // Helpers
  // ****
  function automatic logic [10:0] want(input logic [2:0] e, input logic [2:0] s);
    return {8'h00, e ^ s};
  endfunction : want
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic strobes(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge core_clk);
        k++;
      end while (scanStrobe !== 1'b1 && k < 40);
      if (k >= 40) check("strobe", 11'h000, 11'h001);
      if (k >= 40) close_out();
      @(negedge core_clk);
    end
  endtask : strobes
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    {energize, voltTarget, sense, acOpt, route, pickupDelay, releaseDelay, count} = '0;
    pickupThreshold = {8{9'h064}};
    releaseThreshold = {8{9'h03c}};
    void'($urandom(32'hda40e1ec));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      energize = (i == 0) ? 3'h7 : 3'($urandom);
      sense[2:0] = (i == 0) ? 3'h0 : 3'($urandom);
      route[2:0] = 3'($urandom);
      strobes(2);
      check("state", state & 11'h007, want(energize, sense[2:0]));
      strobes(1);
      check("logic", logicState & 11'h007, want(energize, sense[2:0]));
      strobes(1);
      check("output", outCmd & 11'h007, want(energize, sense[2:0]) & route);
    end
    // A low glitch must throw away the pickup run
    {energize, sense} = '0;
    pickupDelay[41:21] = 21'h00000f;
    strobes(2);
    energize[1] = 1'b1;
    strobes(2);
    check("pickup", state & 11'h002, 11'h000);
    energize[1] = 1'b0;
    strobes(2);
    energize[1] = 1'b1;
    strobes(3);
    check("restart", state & 11'h002, 11'h000);
    strobes(2);
    check("pickup", state & 11'h002, 11'h002);
    pickupDelay[41:21] = 21'h000000;
    acOpt[1] = 1'b1;
    energize[1] = 1'b0;
    strobes(6);
    check("ac hold", state & 11'h002, 11'h002);
    strobes(2);
    check("ac drop", state & 11'h002, 11'h000);
    releaseDelay[62:42] = 21'h00000a;
    energize[2] = 1'b1;
    strobes(2);
    energize[2] = 1'b0;
    strobes(2);
    check("release", state & 11'h004, 11'h004);
    strobes(2);
    check("release", state & 11'h004, 11'h000);
    sense[4] = 1'b1;
    for (int i = 0; i < 7; i++) begin
      acOpt[3] = (i >= 4);
      voltTarget[17:0] = {vTab[i], vTab[i]};
      strobes(9);
      check("threshold", (state >> 3) & 11'h003, {9'h000, eTab[i]});
    end
    for (int i = 0; i < 4; i++) begin
      count = (i == 0) ? 8'hf7 : 8'($urandom);
      repeat (2) @(negedge core_clk);
      for (int e = 0; e < 8; e++) check("number", {3'h0, chanNum[e*8+:8]}, {3'h0, count + e[7:0] + 8'h01});
    end
    close_out();
  end
endmodule : dic_input_conditioner_tb
